// >>> logic/oscsd_pkg.sv
// Constants and types for the output switch counter and status display block
package oscsd_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned HALF_SEC_NS = 500000000;
  localparam int unsigned HALF_SEC_CYC = HALF_SEC_NS / CLK_PERIOD_NS;
  localparam logic [13:0] COUNT_MAX = 14'h270F;
  localparam logic [13:0] COUNT_RESET = 14'h0000;
  localparam logic [13:0] COUNT_STEP = 14'h0001;
  localparam logic [6:0] SUB_LAST = 7'h63;
  localparam logic [6:0] SUB_RESET = 7'h00;
  localparam logic [6:0] SUB_STEP = 7'h01;
  localparam logic [22:0] DIV_RESET = 23'h000000;
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_CH1 = 2'h1;
  localparam logic [1:0] CLR_CH2 = 2'h2;

  typedef enum logic [3:0] {
    SEL_OFF = 4'h0,
    SEL_MANUAL = 4'h1,
    SEL_RESET = 4'h2,
    SEL_ALARM1 = 4'h3,
    SEL_ALARM2 = 4'h4,
    SEL_ALARM3 = 4'h5,
    SEL_ALARM_OR = 4'h6,
    SEL_HEATER = 4'h7,
    SEL_STANDBY = 4'h8
  } oscsd_sel_type;

  typedef enum logic [1:0] {
    D1_PROCESS = 2'b01,
    D1_STATUS = 2'b10
  } oscsd_disp1_type;

  typedef enum logic [4:0] {
    D2_NORMAL = 5'b00001,
    D2_STATUS = 5'b00010,
    D2_PROG = 5'b00100,
    D2_BLANK = 5'b01000,
    D2_COUNT = 5'b10000
  } oscsd_disp2_type;

  typedef struct packed {
    logic manual;
    logic run_reset;
    logic alarm1;
    logic alarm2;
    logic alarm3;
    logic heater_burnout;
    logic heater_short;
    logic heater_overcurrent;
    logic heater_detect;
    logic standby;
  } oscsd_status_type;

  typedef struct packed {
    logic to_ctrl;
    logic to_aux;
    logic to_display;
  } oscsd_route_type;
endpackage : oscsd_pkg

// >>> logic/oscsd_status_sel.sv
// Status condition selector for one display
`timescale 1ns/1ps
module oscsd_status_sel import oscsd_pkg::*; (
  // Selection
  input oscsd_sel_type sel,
  input oscsd_status_type status,
  // Result
  output logic active
);
  wire alarm_or = status.alarm1 | status.alarm2 | status.alarm3;
  wire heater_fault = status.heater_burnout | status.heater_short | status.heater_overcurrent;
  wire heater_on = status.heater_detect & heater_fault;

  // Off and unknown codes never alternate
  assign active = (sel == SEL_MANUAL) ? status.manual :
                  (sel == SEL_RESET) ? status.run_reset :
                  (sel == SEL_ALARM1) ? status.alarm1 :
                  (sel == SEL_ALARM2) ? status.alarm2 :
                  (sel == SEL_ALARM3) ? status.alarm3 :
                  (sel == SEL_ALARM_OR) ? alarm_or :
                  (sel == SEL_HEATER) ? heater_on :
                  (sel == SEL_STANDBY) ? status.standby : 1'b0;
endmodule : oscsd_status_sel

// >>> logic/oscsd_chan_counter.sv
// Switching counter, monitor and count alarm for one control output
`timescale 1ns/1ps
module oscsd_chan_counter import oscsd_pkg::*; (
  // Clock and reset
  input logic sys_clk,
  input logic rst_b,
  // Output under count
  input logic out_level,
  input logic onoff_type,
  // Configuration and events
  input logic [13:0] threshold,
  input logic clear_pulse,
  input logic data_error,
  // Results
  output logic [13:0] monitor_q,
  output logic alarm_q
);
  logic prev_q;
  logic err_q;
  logic [6:0] sub_q;
  logic [6:0] sub_d;
  logic [13:0] mon_d;
  logic err_d;
  logic alarm_d;

  wire thresh_on = (threshold != COUNT_RESET);
  wire count_en = onoff_type && thresh_on;
  wire rise = count_en && out_level && !prev_q;
  wire sub_wrap = rise && (sub_q == SUB_LAST);
  wire [13:0] mon_inc = (monitor_q == COUNT_MAX) ? monitor_q : monitor_q + COUNT_STEP;

  // Error set wins over a clear in the same cycle
  assign err_d = data_error || (err_q && !clear_pulse);
  assign sub_d = (clear_pulse || sub_wrap) ? SUB_RESET : rise ? sub_q + SUB_STEP : sub_q;
  assign mon_d = err_d ? COUNT_MAX : clear_pulse ? COUNT_RESET : sub_wrap ? mon_inc : monitor_q;
  assign alarm_d = err_d || (thresh_on && (mon_d > threshold));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
      err_q <= 1'b0;
      sub_q <= SUB_RESET;
      monitor_q <= COUNT_RESET;
      alarm_q <= 1'b0;
    end else begin
      prev_q <= out_level;
      err_q <= err_d;
      sub_q <= sub_d;
      monitor_q <= mon_d;
      alarm_q <= alarm_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  clear_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clear_pulse && !data_error |=> monitor_q == COUNT_RESET && sub_q == SUB_RESET && !alarm_q)
    else $error("cleared channel not zero");
  error_sat_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    data_error |=> monitor_q == COUNT_MAX && alarm_q)
    else $error("data error did not saturate");
  error_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    err_q && !clear_pulse |=> monitor_q == COUNT_MAX && alarm_q)
    else $error("error state left without clear");
  zero_thresh_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !thresh_on && !clear_pulse |=> sub_q == $past(sub_q))
    else $error("counted with zero threshold");
  linear_out_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !onoff_type && !clear_pulse |=> sub_q == $past(sub_q))
    else $error("counted a linear output");
  monitor_range_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    monitor_q <= COUNT_MAX)
    else $error("monitor above range");
  hundred_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sub_wrap && !clear_pulse && !err_d && monitor_q != COUNT_MAX |=> monitor_q == $past(monitor_q) + COUNT_STEP)
    else $error("monitor did not step after hundred edges");
  alarm_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    alarm_q |-> err_q || ($past(threshold) != COUNT_RESET && monitor_q > $past(threshold)))
    else $error("count alarm without cause");
endmodule : oscsd_chan_counter

// >>> logic/oscsd_top.sv
// Top of the output switch counter and status display block
`timescale 1ns/1ps
module oscsd_top import oscsd_pkg::*; #(
  parameter int unsigned HALF_CYCLES = HALF_SEC_CYC
) (
  // Clock and reset
  input logic sys_clk,
  input logic rst_b,
  // Control outputs under count
  input logic [1:0] ctrl_out,
  input logic [1:0] out_onoff,
  // Counter configuration
  input logic [13:0] ch1_count_alarm_threshold,
  input logic [13:0] ch2_count_alarm_threshold,
  input logic [1:0] count_clear_select,
  input logic [1:0] count_data_error,
  input oscsd_route_type alarm_route,
  // Display configuration
  input oscsd_sel_type first_display_status_select,
  input oscsd_sel_type second_display_status_select,
  // Display conditions
  input oscsd_status_type status,
  input logic process_value_screen,
  input logic prog_end_hold,
  input logic auto_tuning,
  input logic out_of_range,
  // Counter results
  output logic [13:0] ch1_count_monitor,
  output logic [13:0] ch2_count_monitor,
  output logic count_alarm_q,
  output logic count_monitor_visible_q,
  // Alarm routing
  output logic alarm_ctrl_out_q,
  output logic alarm_aux_out_q,
  output logic alarm_display_q,
  // Display content
  output logic phase_q,
  output oscsd_disp1_type disp1_content_q,
  output oscsd_disp2_type disp2_content_q
);

  ////////////////////////////////////////////////////////////////
  // Counter channels
  logic [1:0] clr_sel_q;
  wire [13:0] thresh [2];
  wire [13:0] chan_mon [2];
  wire [1:0] clr_pulse;
  wire [1:0] chan_alarm;

  assign thresh[0] = ch1_count_alarm_threshold;
  assign thresh[1] = ch2_count_alarm_threshold;
  assign ch1_count_monitor = chan_mon[0];
  assign ch2_count_monitor = chan_mon[1];

  // Clear fires once when the selector takes a channel code
  assign clr_pulse[0] = (count_clear_select == CLR_CH1) && (clr_sel_q != CLR_CH1);
  assign clr_pulse[1] = (count_clear_select == CLR_CH2) && (clr_sel_q != CLR_CH2);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      oscsd_chan_counter u_cnt (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .out_level(ctrl_out[gi]),
        .onoff_type(out_onoff[gi]),
        .threshold(thresh[gi]),
        .clear_pulse(clr_pulse[gi]),
        .data_error(count_data_error[gi]),
        .monitor_q(chan_mon[gi]),
        .alarm_q(chan_alarm[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Alarm, visibility and routing
  wire any_thresh = (thresh[0] != COUNT_RESET) || (thresh[1] != COUNT_RESET);
  wire visible_d = any_thresh && (out_onoff != 2'h0);
  wire alarm_d = |chan_alarm;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clr_sel_q <= CLR_NONE;
      count_alarm_q <= 1'b0;
      count_monitor_visible_q <= 1'b0;
    end else begin
      clr_sel_q <= count_clear_select;
      count_alarm_q <= alarm_d;
      count_monitor_visible_q <= visible_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_ctrl_out_q <= 1'b0;
      alarm_aux_out_q <= 1'b0;
      alarm_display_q <= 1'b0;
    end else begin
      alarm_ctrl_out_q <= count_alarm_q && alarm_route.to_ctrl;
      alarm_aux_out_q <= count_alarm_q && alarm_route.to_aux;
      alarm_display_q <= count_alarm_q && alarm_route.to_display;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Half-second alternation phase
  logic [22:0] div_q;
  wire div_wrap = (div_q >= 23'(HALF_CYCLES - 1));
  wire [22:0] div_d = div_wrap ? DIV_RESET : div_q + 23'h000001;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= DIV_RESET;
      phase_q <= 1'b0;
    end else begin
      div_q <= div_d;
      phase_q <= phase_q ^ div_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Status conditions for both displays
  wire stat1_on;
  wire stat2_on;

  oscsd_status_sel u_sel1 (
    .sel(first_display_status_select),
    .status(status),
    .active(stat1_on)
  );

  oscsd_status_sel u_sel2 (
    .sel(second_display_status_select),
    .status(status),
    .active(stat2_on)
  );

  ////////////////////////////////////////////////////////////////
  // Display selection
  wire alt1 = process_value_screen && stat1_on;
  wire alt2 = process_value_screen && stat2_on;
  wire count_alt = process_value_screen && count_alarm_q;
  oscsd_disp1_type disp1_d;
  oscsd_disp2_type disp2_d;
  oscsd_disp2_type disp2_src;

  assign disp1_d = (alt1 && phase_q) ? D1_STATUS : D1_PROCESS;

  // Fixed priority among competing indications
  assign disp2_src = alt2 ? D2_STATUS :
                     prog_end_hold ? D2_PROG :
                     auto_tuning ? D2_BLANK :
                     count_alt ? D2_COUNT :
                     out_of_range ? D2_BLANK : D2_NORMAL;
  assign disp2_d = phase_q ? disp2_src : D2_NORMAL;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      disp1_content_q <= D1_PROCESS;
      disp2_content_q <= D2_NORMAL;
    end else begin
      disp1_content_q <= disp1_d;
      disp2_content_q <= disp2_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  clear_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count_clear_select == CLR_NONE |-> clr_pulse == 2'h0)
    else $error("clear fired with code zero");
  clear_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count_clear_select == CLR_CH1 && clr_sel_q == CLR_NONE |-> clr_pulse == 2'h1)
    else $error("channel one clear not decoded");
  hide_monitor_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !any_thresh || out_onoff == 2'h0 |=> !count_monitor_visible_q)
    else $error("monitor shown while hidden");
  route_aux_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count_alarm_q && alarm_route.to_aux |=> alarm_aux_out_q)
    else $error("alarm not routed to auxiliary output");
  route_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !count_alarm_q |=> !alarm_ctrl_out_q && !alarm_aux_out_q && !alarm_display_q)
    else $error("routed alarm without count alarm");
  alarm_join_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    chan_alarm != 2'h0 |=> count_alarm_q)
    else $error("channel alarm lost");
  phase_flip_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    div_wrap |=> phase_q != $past(phase_q))
    else $error("phase did not toggle at wrap");
  phase_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !div_wrap |=> phase_q == $past(phase_q))
    else $error("phase toggled early");
  first_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    first_display_status_select == SEL_OFF |=> disp1_content_q == D1_PROCESS)
    else $error("first display alternated while off");
  first_alt_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    alt1 && phase_q |=> disp1_content_q == D1_STATUS)
    else $error("first display missed status");
  alarm_or_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    first_display_status_select == SEL_ALARM_OR |-> stat1_on == (status.alarm1 | status.alarm2 | status.alarm3))
    else $error("alarm OR choice wrong");
  heater_none_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    second_display_status_select == SEL_HEATER && !status.heater_detect |-> !stat2_on)
    else $error("heater choice active without detection");
  second_top_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    phase_q && alt2 |=> disp2_content_q == D2_STATUS)
    else $error("status alternation lost priority");
  second_prog_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    phase_q && !alt2 && prog_end_hold |=> disp2_content_q == D2_PROG)
    else $error("program end alternation lost priority");
  second_count_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    phase_q && !alt2 && !prog_end_hold && !auto_tuning && count_alt |=> disp2_content_q == D2_COUNT)
    else $error("count alarm alternation missing");
  second_normal_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !phase_q |=> disp2_content_q == D2_NORMAL)
    else $error("second display not normal in off phase");

  ////////////////////////////////////////////////////////////////
  // Clear, error, saturation and routing checks
  clear_two_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count_clear_select == CLR_CH2 && clr_sel_q == CLR_NONE |-> clr_pulse == 2'h2)
    else $error("channel two clear not decoded");
  clear_held_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count_clear_select == clr_sel_q |-> clr_pulse == 2'h0)
    else $error("held clear code fired again");
  clear_three_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count_clear_select == 2'h3 |-> clr_pulse == 2'h0)
    else $error("unused clear code fired");
  zero_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clr_pulse[0] && !count_data_error[0] |=> ch1_count_monitor == COUNT_RESET)
    else $error("channel one monitor not zero after clear");
  zero_two_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clr_pulse[1] && !count_data_error[1] |=> ch2_count_monitor == COUNT_RESET)
    else $error("channel two monitor not zero after clear");
  error_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count_data_error[0] |=> ch1_count_monitor == COUNT_MAX)
    else $error("channel one error did not saturate");
  error_two_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count_data_error[1] |=> ch2_count_monitor == COUNT_MAX)
    else $error("channel two error did not saturate");
  error_alarm_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count_data_error != 2'h0 |=> ##1 count_alarm_q)
    else $error("data error raised no count alarm");
  sat_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ch1_count_monitor == COUNT_MAX && !clr_pulse[0] |=> ch1_count_monitor == COUNT_MAX)
    else $error("channel one monitor wrapped");
  sat_two_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ch2_count_monitor == COUNT_MAX && !clr_pulse[1] |=> ch2_count_monitor == COUNT_MAX)
    else $error("channel two monitor wrapped");
  alarm_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    chan_alarm == 2'h0 |=> !count_alarm_q)
    else $error("count alarm without channel alarm");
  show_monitor_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    any_thresh && out_onoff != 2'h0 |=> count_monitor_visible_q)
    else $error("monitor hidden while enabled");
  route_ctrl_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count_alarm_q && alarm_route.to_ctrl |=> alarm_ctrl_out_q)
    else $error("alarm not routed to control output");
  route_disp_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count_alarm_q && alarm_route.to_display |=> alarm_display_q)
    else $error("alarm not routed to display");
  route_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !alarm_route.to_aux |=> !alarm_aux_out_q)
    else $error("auxiliary output set while not routed");

  ////////////////////////////////////////////////////////////////
  // Divider and display checks
  div_range_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    div_q <= 23'(HALF_CYCLES - 1))
    else $error("divider past its end");
  div_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !div_wrap |=> div_q == $past(div_q) + 23'h000001)
    else $error("divider did not step");
  first_screen_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !process_value_screen |=> disp1_content_q == D1_PROCESS)
    else $error("first display alternated off screen");
  first_phase_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !phase_q |=> disp1_content_q == D1_PROCESS)
    else $error("first display status in off phase");
  first_cond_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !stat1_on |=> disp1_content_q == D1_PROCESS)
    else $error("first display status without condition");
  second_tune_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    phase_q && !alt2 && !prog_end_hold && auto_tuning |=> disp2_content_q == D2_BLANK)
    else $error("tuning flash lost priority");
  second_range_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    phase_q && !alt2 && !prog_end_hold && !auto_tuning && !count_alt && out_of_range
    |=> disp2_content_q == D2_BLANK)
    else $error("out of range flash missing");
  second_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    phase_q && !alt2 && !prog_end_hold && !auto_tuning && !count_alt && !out_of_range
    |=> disp2_content_q == D2_NORMAL)
    else $error("second display changed without cause");
  screen_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !process_value_screen |=> disp2_content_q != D2_COUNT && disp2_content_q != D2_STATUS)
    else $error("alternation shown off screen");
  or_second_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    second_display_status_select == SEL_ALARM_OR
    |-> stat2_on == (status.alarm1 | status.alarm2 | status.alarm3))
    else $error("second alarm OR choice wrong");
  heater_first_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    first_display_status_select == SEL_HEATER
    |-> stat1_on == (status.heater_detect && (status.heater_burnout || status.heater_short ||
    status.heater_overcurrent)))
    else $error("first heater choice wrong");
  off_second_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    second_display_status_select == SEL_OFF |-> !stat2_on)
    else $error("second display active while off");
endmodule : oscsd_top

// >>> verification/oscsd_relay_model.sv
// Behavioural model of the relay or SSR drive outputs feeding the counter
`timescale 1ns/1ps
module oscsd_relay_model (
  // Clock
  input wire logic sys_clk,
  // Drive levels
  output logic [1:0] ctrl_out
);
  initial ctrl_out = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Off-to-on pulses, off time one or two cycles so prompt and slow both occur
  task automatic pulse(input logic [1:0] mask, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      #10 ctrl_out = mask;
      @(posedge sys_clk);
      #10 ctrl_out = 2'h0;
      repeat ($urandom % 2) @(posedge sys_clk);
    end
  endtask : pulse
endmodule : oscsd_relay_model

// >>> verification/oscsd_bench.sv
// Self-checking bench for the output switch counter and status display block
`timescale 1ns/1ps
module oscsd_bench import oscsd_pkg::*;;
  logic sys_clk, rst_b, ca, vis, r_ctrl, r_aux, r_disp, phase, scr, prog, tun, oor, ca_exp;
  logic [1:0] ctrl_out, out_onoff, count_clear_select, count_data_error;
  logic [13:0] thr1, thr2, mon1, mon2;
  oscsd_route_type alarm_route;
  oscsd_sel_type sel1, sel2;
  oscsd_status_type status;
  oscsd_disp1_type d1;
  oscsd_disp2_type d2;
  int fails, n_compared;

  oscsd_top #(.HALF_CYCLES(4)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .ctrl_out(ctrl_out),
    .out_onoff(out_onoff), .ch1_count_alarm_threshold(thr1), .ch2_count_alarm_threshold(thr2),
    .count_clear_select(count_clear_select), .count_data_error(count_data_error),
    .alarm_route(alarm_route), .first_display_status_select(sel1),
    .second_display_status_select(sel2), .status(status), .process_value_screen(scr),
    .prog_end_hold(prog), .auto_tuning(tun), .out_of_range(oor), .ch1_count_monitor(mon1),
    .ch2_count_monitor(mon2), .count_alarm_q(ca), .count_monitor_visible_q(vis),
    .alarm_ctrl_out_q(r_ctrl), .alarm_aux_out_q(r_aux), .alarm_display_q(r_disp),
    .phase_q(phase), .disp1_content_q(d1), .disp2_content_q(d2));

  oscsd_relay_model u_relay (.sys_clk(sys_clk), .ctrl_out(ctrl_out));

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers
  task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      fails++;
    end
  endtask : check

  task automatic conclude();
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask : cyc

  function automatic logic exp_active(input oscsd_sel_type s, input oscsd_status_type st);
    case (s)
      SEL_MANUAL: return st.manual;
      SEL_RESET: return st.run_reset;
      SEL_ALARM1: return st.alarm1;
      SEL_ALARM2: return st.alarm2;
      SEL_ALARM3: return st.alarm3;
      SEL_ALARM_OR: return st.alarm1 | st.alarm2 | st.alarm3;
      SEL_HEATER: return st.heater_detect & (st.heater_burnout | st.heater_short | st.heater_overcurrent);
      SEL_STANDBY: return st.standby;
      default: return 1'b0;
    endcase
  endfunction : exp_active

  function automatic oscsd_disp2_type exp_d2(input logic p);
    if (!p) return D2_NORMAL;
    if (scr && exp_active(sel2, status)) return D2_STATUS;
    if (prog) return D2_PROG;
    if (tun) return D2_BLANK;
    if (scr && ca_exp) return D2_COUNT;
    if (oor) return D2_BLANK;
    return D2_NORMAL;
  endfunction : exp_d2

  ////////////////////////////////////////////////////////////////////////////
  // Random display conditions, watched over two half-second phases
  task automatic disp_round(input int iters);
    logic p;
    int tg;
    for (int i = 0; i < iters; i++) begin
      sel1 = oscsd_sel_type'($urandom % 9);
      sel2 = oscsd_sel_type'($urandom % 9);
      status = oscsd_status_type'(10'($urandom));
      {scr, prog, tun, oor} = 4'($urandom);
      tg = 0;
      cyc(2);
      for (int k = 0; k < 8; k++) begin
        p = phase;
        cyc(1);
        tg += int'(phase !== p);
        check("disp1", 14'(d1), 14'((p && scr && exp_active(sel1, status)) ? D1_STATUS : D1_PROCESS));
        check("disp2", 14'(d2), 14'(exp_d2(p)));
      end
      check("phase_flips", 14'(tg), 14'h0002);
    end
  endtask : disp_round

  task automatic clear_chan(input logic [1:0] code);
    count_clear_select = code;
    cyc(1);
    count_clear_select = CLR_NONE;
    cyc(4);
  endtask : clear_chan

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    void'($urandom(49));
    fails = 0;
    n_compared = 0;
    ca_exp = 1'b0;
    rst_b = 1'b0;
    out_onoff = 2'h3;
    thr1 = 14'h0000;
    thr2 = 14'h0000;
    count_clear_select = CLR_NONE;
    count_data_error = 2'h0;
    alarm_route = oscsd_route_type'(3'($urandom));
    sel1 = SEL_OFF;
    sel2 = SEL_OFF;
    status = '0;
    {scr, prog, tun, oor} = 4'h0;
    repeat (3) @(posedge sys_clk);
    #10 rst_b = 1'b1;
    check("ch1_monitor", mon1, 14'h0000);
    u_relay.pulse(2'h3, 100);
    cyc(4);
    check("ch1_monitor", mon1, 14'h0000);
    check("ch2_monitor", mon2, 14'h0000);
    check("visible", 14'(vis), 14'h0000);
    disp_round(10);
    thr1 = 14'h0001;
    thr2 = 14'(1 + $urandom % 9999);
    out_onoff = 2'h1;
    u_relay.pulse(2'h3, 100);
    cyc(4);
    check("ch1_monitor", mon1, 14'h0001);
    check("ch2_monitor", mon2, 14'h0000);
    check("count_alarm", 14'(ca), 14'h0000);
    check("visible", 14'(vis), 14'h0001);
    u_relay.pulse(2'h1, 100);
    cyc(4);
    check("ch1_monitor", mon1, 14'h0002);
    check("count_alarm", 14'(ca), 14'h0001);
    check("routes", 14'({r_ctrl, r_aux, r_disp}), 14'(alarm_route));
    clear_chan(CLR_CH2);
    check("ch1_monitor", mon1, 14'h0002);
    clear_chan(CLR_CH1);
    check("ch1_monitor", mon1, 14'h0000);
    check("count_alarm", 14'(ca), 14'h0000);
    out_onoff = 2'h0;
    cyc(3);
    check("visible", 14'(vis), 14'h0000);
    out_onoff = 2'h3;
    alarm_route = oscsd_route_type'(3'($urandom));
    count_data_error = 2'h2;
    cyc(1);
    count_data_error = 2'h0;
    cyc(4);
    check("ch2_monitor", mon2, COUNT_MAX);
    check("count_alarm", 14'(ca), 14'h0001);
    check("routes", 14'({r_ctrl, r_aux, r_disp}), 14'(alarm_route));
    ca_exp = 1'b1;
    disp_round(30);
    clear_chan(2'h3);
    check("ch2_monitor", mon2, COUNT_MAX);
    check("count_alarm", 14'(ca), 14'h0001);
    clear_chan(CLR_CH2);
    check("ch2_monitor", mon2, 14'h0000);
    check("count_alarm", 14'(ca), 14'h0000);
    conclude();
  end
endmodule : oscsd_bench
